// >>> clkdiv_checker.sv
`timescale 1ns/1ps

module clkdiv_checker (
   input wire logic       sys_clk,
   input wire logic       sys_rst,
   input wire logic       ref_clk_in,
   input wire logic       divider_select_high,
   input wire logic       divider_select_low,
   input wire logic       slave_addr_pin_high,
   input wire logic       slave_addr_pin_low,
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe,
   input wire logic [7:0] clock_output_pair_p,
   input wire logic [7:0] clock_output_pair_n,
   input wire logic [7:0] clock_output_pair_oe
);
   // ------------------------------------------------------------
   // Interval meters
   // ------------------------------------------------------------
   // The ratio check waits for a settled select, since the first
   // output period after a change may be short.
   logic [9:0] rcnt_q, rcnt_d, hlen_q, hlen_d, pcnt_q, pcnt_d;
   logic [9:0] age_q, age_d;
   logic [1:0] sel_q, sel_d;
   logic       ref_q, ref_d, p_q, p_d;

   always_comb begin
      ref_d  = ref_clk_in;
      p_d    = clock_output_pair_p[0];
      sel_d  = {divider_select_high, divider_select_low};
      rcnt_d = (ref_d != ref_q) ? 10'h001 : rcnt_q + 10'h001;
      hlen_d = (ref_d != ref_q) ? rcnt_q : hlen_q;
      pcnt_d = (p_d != p_q) ? 10'h001 : pcnt_q + 10'h001;
      age_d  = (sel_d != sel_q) ? 10'h000 : age_q + {9'h0, age_q != 10'h3ff};
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {ref_q, p_q, sel_q, rcnt_q, hlen_q, pcnt_q, age_q} <= '0;
      end else begin
         {ref_q, p_q, sel_q, rcnt_q, hlen_q, pcnt_q, age_q} <=
            {ref_d, p_d, sel_d, rcnt_d, hlen_d, pcnt_d, age_d};
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_scl_high3;
      scl_in [*3];
   endsequence

   a_ratio_follows_select: assert property (
      p_d != p_q && age_q == 10'h3ff |-> pcnt_q == (hlen_q << sel_q))
      else $error("output period does not match the select");
   a_pairs_share_clock: assert property (
      clock_output_pair_p == {8{clock_output_pair_p[0]}})
      else $error("output pairs differ");
   a_pair_is_complement: assert property (
      clock_output_pair_n == ~clock_output_pair_p)
      else $error("pair halves not complementary");
   a_reset_all_disabled: assert property (
      $fell(sys_rst) |-> clock_output_pair_oe == 8'h00)
      else $error("outputs enabled after reset");
   a_enable_needs_write: assert property (
      !$stable(clock_output_pair_oe) |-> ##[0:6] sda_oe)
      else $error("enables changed without an accepted byte");
   a_sda_moves_low: assert property (
      $changed(sda_oe) |-> !scl_in)
      else $error("data line moved while clock high");
   a_ack_held_high: assert property (
      $rose(scl_in) && sda_oe |-> sda_oe throughout s_scl_high3)
      else $error("acknowledge released early");
   a_sda_open_drain: assert property (
      sda_out == 1'b0)
      else $error("data line driven high");
endmodule : clkdiv_checker

bind clock_divider_i2c_output_enable clkdiv_checker clkdiv_checker_i (.*);

// >>> clkdiv_fanout_pkg.sv
package clkdiv_fanout_pkg;

   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [7:0] OUTPUT_ENABLE_MASK_IDX   = 8'h00;
   localparam logic [7:0] OUTPUT_ENABLE_MASK_RESET = 8'hff;

   // -------------------------------------------------------------------
   // Serial slave address
   // -------------------------------------------------------------------
   localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h1a;
   localparam int         RW_BIT           = 0;

   // -------------------------------------------------------------------
   // Divider select codes and toggle intervals in reference rising edges, less one
   // -------------------------------------------------------------------
   localparam logic [1:0] DIV_SEL_BY1 = 2'h0;
   localparam logic [1:0] DIV_SEL_BY2 = 2'h1;
   localparam logic [1:0] DIV_SEL_BY4 = 2'h2;
   localparam logic [1:0] DIV_SEL_BY8 = 2'h3;
   localparam logic [1:0] HALF_BY2    = 2'h0;
   localparam logic [1:0] HALF_BY4    = 2'h1;
   localparam logic [1:0] HALF_BY8    = 2'h3;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_ADDR      = 4'b0001,
      ST_ADDR_ACK  = 4'b0010,
      ST_INDEX     = 4'b0011,
      ST_INDEX_ACK = 4'b0100,
      ST_DATA      = 4'b0101,
      ST_DATA_ACK  = 4'b0110,
      ST_READ      = 4'b0111,
      ST_READ_ACK  = 4'b1000
   } slave_state_t;

endpackage : clkdiv_fanout_pkg

// >>> clock_divider_i2c_output_enable.sv
`timescale 1ns/1ps

// How it works
// - Select pair 00/01/10/11 divides reference by 1/2/4/8, high pin MSB.
// - Both select pins low gives divide-by-one pass-through.
// - Select pins are asynchronous and pass a synchroniser first.
// - One 8-bit enable register at index 0, bit n for pair n.
// - Bit 0 drives the pair, bit 1 puts it in high impedance.
// - Reset sets all enable bits to 1, all pairs disabled.
// - An accepted write sets every pair's enable from the register.
// - Enable changes are not aligned to the reference clock.
// - Serial slave supports standard write and read of the register.
// - Address is 11010 then the two address pins, upper first.
// - Bit 0 of the address byte selects read or write.
// - START is SDA falling while SCL is high.
// - STOP is SDA rising while SCL is high.
// - SDA changes only while SCL is low.
// - Acknowledge holds SDA low from before SCL rise to its fall.
// - SDA is open drain: pulled low or released, never driven high.
module clock_divider_i2c_output_enable
   import clkdiv_fanout_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   input  wire logic       ref_clk_in,
   input  wire logic       divider_select_high,
   input  wire logic       divider_select_low,
   input  wire logic       slave_addr_pin_high,
   input  wire logic       slave_addr_pin_low,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   output logic [7:0]      clock_output_pair_p,
   output logic [7:0]      clock_output_pair_n,
   output logic [7:0]      clock_output_pair_oe
);

   // -------------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------------
   logic [6:0] raw_in;
   logic [6:0] sync_in;
   logic       ref_s;
   logic [1:0] sel_s;
   logic [1:0] addr_s;
   logic       scl_s;
   logic       sda_s;

   assign raw_in = {ref_clk_in, divider_select_high, divider_select_low,
                    slave_addr_pin_high, slave_addr_pin_low,
                    scl_in, sda_in};

   sync2 #(
      .WIDTH    (7)
   ) u_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .async_in (raw_in),
      .sync_out (sync_in)
   );

   assign ref_s  = sync_in[6];
   assign sel_s  = sync_in[5:4];
   assign addr_s = sync_in[3:2];
   assign scl_s  = sync_in[1];
   assign sda_s  = sync_in[0];

   // -------------------------------------------------------------------
   // Reference divider
   // -------------------------------------------------------------------
   // The reference is sampled, so it must stay below a quarter of sys_clk.
   logic       ref_prev_q;
   logic [1:0] div_cnt_q,  div_cnt_d;
   logic       div_clk_q,  div_clk_d;
   logic [7:0] pair_p_q,   pair_p_d;
   logic [7:0] pair_n_q,   pair_n_d;
   logic       ref_rise;
   logic [1:0] half_lim;

   assign ref_rise = ref_s & ~ref_prev_q;

   always_comb begin
      unique case (sel_s)
         DIV_SEL_BY2: half_lim = HALF_BY2;
         DIV_SEL_BY4: half_lim = HALF_BY4;
         DIV_SEL_BY8: half_lim = HALF_BY8;
         DIV_SEL_BY1: half_lim = HALF_BY2;
      endcase
      div_cnt_d = div_cnt_q;
      div_clk_d = div_clk_q;
      if (ref_rise) begin
         if (div_cnt_q >= half_lim) begin
            div_cnt_d = 2'h0;
            div_clk_d = ~div_clk_q;
         end else begin
            div_cnt_d = div_cnt_q + 2'h1;
         end
      end
      if (sel_s == DIV_SEL_BY1) begin
         pair_p_d = {8{ref_s}};
      end else begin
         pair_p_d = {8{div_clk_d}};
      end
      pair_n_d = ~pair_p_d;
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_prev_q <= 1'b0;
         div_cnt_q  <= 2'h0;
         div_clk_q  <= 1'b0;
         pair_p_q   <= 8'h00;
         pair_n_q   <= 8'hff;
      end else begin
         ref_prev_q <= ref_s;
         div_cnt_q  <= div_cnt_d;
         div_clk_q  <= div_clk_d;
         pair_p_q   <= pair_p_d;
         pair_n_q   <= pair_n_d;
      end
   end

   // -------------------------------------------------------------------
   // Serial slave
   // -------------------------------------------------------------------
   slave_state_t state_q,     state_d;
   logic         scl_prev_q;
   logic         sda_prev_q;
   logic [7:0]   shift_q,     shift_d;
   logic [2:0]   bit_cnt_q,   bit_cnt_d;
   logic         byte_done_q, byte_done_d;
   logic         rw_q,        rw_d;
   logic [7:0]   index_q,     index_d;
   logic [7:0]   mask_q,      mask_d;
   logic         sda_oe_q,    sda_oe_d;
   logic [7:0]   pair_oe_q;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_det;
   logic         stop_det;
   logic [7:0]   read_data;

   assign scl_rise  = scl_s & ~scl_prev_q;
   assign scl_fall  = ~scl_s & scl_prev_q;
   assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
   assign read_data = (index_q == OUTPUT_ENABLE_MASK_IDX) ? mask_q : 8'h00;

   always_comb begin
      state_d     = state_q;
      shift_d     = shift_q;
      bit_cnt_d   = bit_cnt_q;
      byte_done_d = byte_done_q;
      rw_d        = rw_q;
      index_d     = index_q;
      mask_d      = mask_q;
      sda_oe_d    = sda_oe_q;
      if (start_det) begin
         state_d     = ST_ADDR;
         bit_cnt_d   = 3'h0;
         byte_done_d = 1'b0;
         sda_oe_d    = 1'b0;
      end else if (stop_det) begin
         state_d  = ST_IDLE;
         sda_oe_d = 1'b0;
      end else if (scl_rise) begin
         unique case (state_q)
            ST_ADDR, ST_INDEX, ST_DATA: begin
               shift_d     = {shift_q[6:0], sda_s};
               bit_cnt_d   = bit_cnt_q + 3'h1;
               byte_done_d = (bit_cnt_q == 3'h7);
            end
            ST_READ: begin
               shift_d     = {shift_q[6:0], 1'b0};
               bit_cnt_d   = bit_cnt_q + 3'h1;
               byte_done_d = (bit_cnt_q == 3'h7);
            end
            ST_READ_ACK: begin
               if (sda_s) begin
                  state_d = ST_IDLE;
               end else begin
                  state_d = ST_READ;
               end
            end
            default: ;
         endcase
      // SDA only moves after SCL falls
      end else if (scl_fall) begin
         unique case (state_q)
            ST_ADDR: begin
               if (byte_done_q) begin
                  byte_done_d = 1'b0;
                  if (shift_q[7:1] == {SLAVE_ADDR_FIXED, addr_s}) begin
                     rw_d     = shift_q[RW_BIT];
                     sda_oe_d = 1'b1;
                     state_d  = ST_ADDR_ACK;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (rw_q) begin
                  shift_d  = read_data;
                  sda_oe_d = ~read_data[7];
                  state_d  = ST_READ;
               end else begin
                  sda_oe_d = 1'b0;
                  state_d  = ST_INDEX;
               end
            end
            ST_INDEX: begin
               if (byte_done_q) begin
                  byte_done_d = 1'b0;
                  index_d     = shift_q;
                  sda_oe_d    = 1'b1;
                  state_d     = ST_INDEX_ACK;
               end
            end
            ST_DATA: begin
               if (byte_done_q) begin
                  byte_done_d = 1'b0;
                  if (index_q == OUTPUT_ENABLE_MASK_IDX) begin
                     mask_d = shift_q;
                  end
                  sda_oe_d = 1'b1;
                  state_d  = ST_DATA_ACK;
               end
            end
            ST_INDEX_ACK, ST_DATA_ACK: begin
               sda_oe_d = 1'b0;
               state_d  = ST_DATA;
            end
            ST_READ: begin
               if (byte_done_q) begin
                  byte_done_d = 1'b0;
                  sda_oe_d    = 1'b0;
                  shift_d     = read_data;
                  state_d     = ST_READ_ACK;
               end else begin
                  sda_oe_d = ~shift_q[7];
               end
            end
            ST_READ_ACK: begin
               sda_oe_d = ~shift_q[7];
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q     <= ST_IDLE;
         scl_prev_q  <= 1'b0;
         sda_prev_q  <= 1'b0;
         shift_q     <= 8'h00;
         bit_cnt_q   <= 3'h0;
         byte_done_q <= 1'b0;
         rw_q        <= 1'b0;
         index_q     <= 8'h00;
         mask_q      <= OUTPUT_ENABLE_MASK_RESET;
         sda_oe_q    <= 1'b0;
         pair_oe_q   <= 8'h00;
      end else begin
         state_q     <= state_d;
         scl_prev_q  <= scl_s;
         sda_prev_q  <= sda_s;
         shift_q     <= shift_d;
         bit_cnt_q   <= bit_cnt_d;
         byte_done_q <= byte_done_d;
         rw_q        <= rw_d;
         index_q     <= index_d;
         mask_q      <= mask_d;
         sda_oe_q    <= sda_oe_d;
         pair_oe_q   <= ~mask_d;
      end
   end

   assign sda_out              = 1'b0;
   assign sda_oe               = sda_oe_q;
   assign clock_output_pair_p  = pair_p_q;
   assign clock_output_pair_n  = pair_n_q;
   assign clock_output_pair_oe = pair_oe_q;

endmodule : clock_divider_i2c_output_enable

// >>> clock_divider_i2c_output_enable_test.sv
`timescale 1ns/1ps

module clock_divider_i2c_output_enable_test import clkdiv_fanout_pkg::*;;
   logic       sys_clk, sys_rst, ref_clk, scl, sda_low, sda_oe, sda_out;
   logic       sel_hi, sel_lo, adr_hi, adr_lo;
   logic [7:0] pair_p, pair_n, pair_oe;
   wire        sda_line = ~(sda_low | sda_oe);
   wire  [6:0] dev = {SLAVE_ADDR_FIXED, adr_hi, adr_lo};
   int         error_cnt = 0;
   int         checks = 0;

   clock_divider_i2c_output_enable clock_divider_i2c_output_enable_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .ref_clk_in(ref_clk),
      .divider_select_high(sel_hi), .divider_select_low(sel_lo),
      .slave_addr_pin_high(adr_hi), .slave_addr_pin_low(adr_lo),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .clock_output_pair_p(pair_p),
      .clock_output_pair_n(pair_n), .clock_output_pair_oe(pair_oe));
   ctrl_model ctrl_model_i (.sys_clk(sys_clk), .sda_line(sda_line),
      .scl(scl), .sda_low(sda_low), .ref_clk(ref_clk));

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   task automatic conclude;
      if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task automatic wr(input logic [6:0] a, input logic [7:0] idx, dat,
                     output logic [2:0] ack);
      logic [8:0] r;
      ctrl_model_i.start();
      ctrl_model_i.bits({a, 1'b0, 1'b1}, r);
      ack[2] = r[0];
      ctrl_model_i.bits({idx, 1'b1}, r);
      ack[1] = r[0];
      ctrl_model_i.bits({dat, 1'b1}, r);
      ack[0] = r[0];
      ctrl_model_i.stop();
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [7:0] d);
      logic [8:0] r;
      ctrl_model_i.start();
      ctrl_model_i.bits({dev, 1'b0, 1'b1}, r);
      ctrl_model_i.bits({idx, 1'b1}, r);
      ctrl_model_i.start();
      ctrl_model_i.bits({dev, 1'b1, 1'b1}, r);
      check({7'h0, r[0]}, 8'h00);
      ctrl_model_i.bits(9'h1ff, r);
      d = r[8:1];
      ctrl_model_i.stop();
   endtask : rd

   task automatic t_write_read;
      logic [7:0] masks [4] = '{8'hf0, 8'h5a, 8'h00, 8'hff};
      logic [2:0] ack;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         {adr_hi, adr_lo} = i[1:0];
         ctrl_model_i.half();
         wr(dev, OUTPUT_ENABLE_MASK_IDX, masks[i], ack);
         check({5'h0, ack}, 8'h00);
         check(pair_oe, ~masks[i]);
         rd(OUTPUT_ENABLE_MASK_IDX, d);
         check(d, masks[i]);
      end
   endtask : t_write_read

   task automatic t_refuse;
      logic [2:0] ack;
      logic [7:0] d;
      wr(dev ^ 7'h01, OUTPUT_ENABLE_MASK_IDX, 8'h00, ack);
      check({5'h0, ack}, 8'h07);
      check(pair_oe, 8'h00);
      wr(dev, 8'h01, 8'h00, ack);
      check({5'h0, ack}, 8'h00);
      check(pair_oe, 8'h00);
      rd(8'h01, d);
      check(d, 8'h00);
   endtask : t_refuse

   task automatic t_reset;
      sys_rst = 1'b1;
      repeat (4) @(negedge sys_clk);
      check(pair_oe, 8'h00);
      sys_rst = 1'b0;
      repeat (5) @(negedge sys_clk);
   endtask : t_reset

   // A master acknowledge asks for the same register once more.
   task automatic t_read_repeat;
      logic [2:0] ack;
      logic [8:0] r;
      wr(dev, OUTPUT_ENABLE_MASK_IDX, 8'h3c, ack);
      check({5'h0, ack}, 8'h00);
      ctrl_model_i.start();
      ctrl_model_i.bits({dev, 1'b0, 1'b1}, r);
      ctrl_model_i.bits({OUTPUT_ENABLE_MASK_IDX, 1'b1}, r);
      ctrl_model_i.start();
      ctrl_model_i.bits({dev, 1'b1, 1'b1}, r);
      ctrl_model_i.bits(9'h1fe, r);
      check(r[8:1], 8'h3c);
      ctrl_model_i.bits(9'h1ff, r);
      check(r[8:1], 8'h3c);
      ctrl_model_i.stop();
      check(pair_oe, 8'hc3);
   endtask : t_read_repeat

   // A second reset in mid-run must bring the mask back to all ones.
   task automatic t_rerun;
      logic [7:0] d;
      t_reset();
      rd(OUTPUT_ENABLE_MASK_IDX, d);
      check(d, OUTPUT_ENABLE_MASK_RESET);
      check(pair_oe, 8'h00);
   endtask : t_rerun

   task automatic gap(output int n);
      logic v;
      v = pair_p[0];
      n = 0;
      while (pair_p[0] === v && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 200) begin
         error_cnt++;
         $display("wrong value at %0t: no output toggle", $time);
         conclude();
      end
   endtask : gap

   task automatic t_divider;
      int n;
      for (int s = 0; s < 4; s++) begin
         {sel_hi, sel_lo} = s[1:0];
         repeat (1100) @(negedge sys_clk);
         gap(n);
         gap(n);
         check(n[7:0], 8'h08 << s);
      end
   endtask : t_divider

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   initial begin
      {sel_hi, sel_lo, adr_hi, adr_lo} = 4'h0;
      t_reset();
      t_write_read();
      t_refuse();
      t_read_repeat();
      t_rerun();
      t_divider();
      conclude();
   end
endmodule : clock_divider_i2c_output_enable_test

// >>> ctrl_model.sv
`timescale 1ns/1ps

module ctrl_model (
   input  wire logic sys_clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low,
   output logic      ref_clk
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      ref_clk = 1'b0;
   end

   // The reference runs free; eight system cycles per half period
   // keeps it well below the synchroniser's limit.
   always #160 ref_clk = ~ref_clk;

   task automatic half;
      repeat (10) @(negedge sys_clk);
   endtask : half

   task automatic start;
      sda_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b1;
      half();
      scl = 1'b0;
      half();
   endtask : start

   task automatic stop;
      sda_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b0;
      half();
   endtask : stop

   // data moves only while clock is low.
   task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_low = !tx[i];
         half();
         scl = 1'b1;
         half();
         rx[i] = sda_line;
         scl = 1'b0;
         half();
      end
   endtask : bits
endmodule : ctrl_model

// >>> sync2.sv
`timescale 1ns/1ps

// -------------------------------------------------------------------
// Two-stage synchroniser
// -------------------------------------------------------------------
// The first stage is read only by the second stage.
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule : sync2
